// File: rtl/pll_mode_and_reset_control.sv
// pll mode and reset controller: nvm init, hard/soft reset, per pll modes, bandwidth select
//
// Overview of operation
// - after power-up, copy every configuration word from nvm before anything runs.
// - bus transactions are not acknowledged until the nvm load has finished.
// - all output enables stay low until the nvm load has finished.
// - hard reset reloads nvm and returns every circuit, bus included, to start.
// - hard reset starts from the low reset pin or the hard reset bit.
// - soft reset skips nvm and only applies the current register values.
// - hard reset hits all plls; soft reset targets all or any single pll.
// - each pll runs its own four-state mode machine after the load.
// - every pll starts in free-run as soon as the load completes.
// - in free-run the pll follows only the reference input pins.
// - each pll has its own loop bandwidth code, 0.1 Hz to 4 kHz.
// - with fastlock on, a separate 100 Hz to 4 kHz bandwidth applies during acquisition.
// - once acquisition ends the normal loop bandwidth is applied again.
// - each pll plan is fractional input divider, fractional multiplier, integer output divider.
// - any of four inputs per pll, manual or automatic; crosspoint maps outputs to plls.
// - a pll starts acquisition once any configured input is valid.
// - a pll that has locked since the load enters holdover when its input fails and no other is valid; else it returns to free-run.
`timescale 1ns/1ns
`include "pll_ctrl_regs.svh"

module pll_mode_and_reset_control (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        HARD_RESET_PIN_N_I,
	input  wire logic [31:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic             WB_ACK_O,
	output logic             NVM_RD_O,
	output logic      [4:0]  NVM_ADDR_O,
	input  wire logic [31:0] NVM_DATA_I,
	input  wire logic [3:0]  INPUT_VALID_I,
	input  wire logic [3:0]  PLL_LOCKED_I,
	output logic             INIT_DONE_O,
	output logic      [7:0]  PLL_MODE_O,
	output logic      [7:0]  PLL_INSEL_O,
	output logic      [3:0]  PLL_TRACK_INPUT_O,
	output logic      [19:0] PLL_BW_O,
	output logic      [127:0] PLL_PDIV_O,
	output logic      [127:0] PLL_MDIV_O,
	output logic      [127:0] PLL_RDIV_O,
	output logic      [15:0] OUT_PLL_SEL_O,
	output logic      [7:0]  OUT_EN_O,
	output logic             IRQ_O
);

	// lowest-index valid candidate: bit 2 says one was found, bits 1:0 its index
	function automatic logic [2:0] pick_input(input logic [3:0] cand);
		logic [2:0] res;
		res = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			if (cand[i]) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction : pick_input

	// candidate inputs of one pll: a single input in manual mode, the mask otherwise
	function automatic logic [3:0] cand_mask(input logic [31:0] ctrl);
		logic [3:0] m;
		m = 4'h0;
		if (ctrl[`CTRL_AUTO_SEL_BIT]) begin
			m = ctrl[`CTRL_IN_MASK_LSB +: 4];
		end else begin
			m[ctrl[`CTRL_MAN_IN_LSB +: 2]] = 1'b1;
		end
		return m;
	endfunction : cand_mask

	// pin and analog status come from other domains: two flops before use
	logic        pin_meta_reg;
	logic        pin_n_reg;
	logic [3:0]  valid_meta_reg;
	logic [3:0]  valid_reg;
	logic [3:0]  lock_meta_reg;
	logic [3:0]  lock_reg;
	logic        hard_bit_reg;
	logic        rst_all;

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_meta_reg   <= 1'b1;
			pin_n_reg      <= 1'b1;
			valid_meta_reg <= 4'h0;
			valid_reg      <= 4'h0;
			lock_meta_reg  <= 4'h0;
			lock_reg       <= 4'h0;
		end else begin
			pin_meta_reg   <= HARD_RESET_PIN_N_I;
			pin_n_reg      <= pin_meta_reg;
			valid_meta_reg <= INPUT_VALID_I;
			valid_reg      <= valid_meta_reg;
			lock_meta_reg  <= PLL_LOCKED_I;
			lock_reg       <= lock_meta_reg;
		end
	end

	// hard reset behaves like power-up; the bit pulse is kept outside rst_all
	assign rst_all = RST_I | ~pin_n_reg | hard_bit_reg;

	logic                  phase_is_run;
	pll_ctrl_pkg::phase_t  phase_reg;
	logic [4:0]            load_idx_reg;
	logic                  cap_valid_reg;
	logic [4:0]            cap_idx_reg;
	logic                  load_done;

	// nvm read port answers one cycle after the address is issued
	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			phase_reg     <= pll_ctrl_pkg::PH_NVM_LOAD;
			load_idx_reg  <= 5'h00;
			cap_valid_reg <= 1'b0;
			cap_idx_reg   <= 5'h00;
		end else if (phase_reg == pll_ctrl_pkg::PH_NVM_LOAD) begin
			cap_valid_reg <= (load_idx_reg <= `CFG_LAST_IDX);
			cap_idx_reg   <= load_idx_reg;
			if (load_idx_reg <= `CFG_LAST_IDX) begin
				load_idx_reg <= load_idx_reg + 5'h01;
			end
			if (load_done) begin
				phase_reg <= pll_ctrl_pkg::PH_RUN;
			end
		end
	end

	assign load_done    = cap_valid_reg && (cap_idx_reg == `CFG_LAST_IDX);
	assign phase_is_run = (phase_reg == pll_ctrl_pkg::PH_RUN);
	assign NVM_RD_O     = (phase_reg == pll_ctrl_pkg::PH_NVM_LOAD) && (load_idx_reg <= `CFG_LAST_IDX);
	assign NVM_ADDR_O   = load_idx_reg;
	assign INIT_DONE_O  = phase_is_run;

	// wishbone slave: ack only once running, one cycle after the request
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic [7:0]  adr;
	logic        wr_ack;
	logic        is_cfg;
	logic [4:0]  cfg_idx;

	assign adr     = WB_ADR_I[7:0];
	assign is_cfg  = (WB_ADR_I[31:8] == 24'h000000) && (adr <= `REG_CFG_LAST_ADDR) && (adr[1:0] == 2'h0);
	assign cfg_idx = adr[6:2];
	assign wr_ack  = ack_reg && WB_CYC_I && WB_STB_I && WB_WE_I;

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg && phase_is_run;
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = rdat_reg;

	// configuration words: nvm copy during load, bus writes afterwards
	logic [31:0] cfg_mem [`CFG_WORDS];
	logic [31:0] act_mem [`CFG_WORDS];

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			for (int i = 0; i < `CFG_WORDS; i++) begin
				cfg_mem[i] <= 32'h00000000;
			end
		end else if (cap_valid_reg && !phase_is_run) begin
			cfg_mem[cap_idx_reg] <= NVM_DATA_I;
		end else if (wr_ack && is_cfg) begin
			for (int b = 0; b < 4; b++) begin
				if (WB_SEL_I[b]) begin
					cfg_mem[cfg_idx][8*b +: 8] <= WB_DAT_I[8*b +: 8];
				end
			end
		end
	end

	// control register: write-only pulses, hard reset pulse survives rst_all
	logic [3:0] soft_reg;
	logic [3:0] soft_next;

	always_comb begin
		soft_next = 4'h0;
		if (wr_ack && (adr == `REG_CONTROL_ADDR) && WB_SEL_I[0]) begin
			soft_next = WB_DAT_I[`CTL_SOFT_ALL_BIT] ? 4'hf : WB_DAT_I[`CTL_SOFT_PLL_LSB +: 4];
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			hard_bit_reg <= 1'b0;
		end else begin
			hard_bit_reg <= wr_ack && (adr == `REG_CONTROL_ADDR) && WB_SEL_I[0]
				&& WB_DAT_I[`CTL_HARD_BIT];
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			soft_reg <= 4'h0;
		end else begin
			soft_reg <= soft_next;
		end
	end

	// applied copy: loaded at init end, refreshed per pll by soft reset only
	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			for (int i = 0; i < `CFG_WORDS; i++) begin
				act_mem[i] <= 32'h00000000;
			end
		end else if (load_done && !phase_is_run) begin
			for (int i = 0; i < `CFG_LAST_IDX; i++) begin
				act_mem[i] <= cfg_mem[i];
			end
			act_mem[`CFG_XPOINT_IDX] <= NVM_DATA_I; // last word arrives this cycle
		end else begin
			for (int p = 0; p < `PLL_COUNT; p++) begin
				if (soft_reg[p]) begin
					for (int w = 0; w < `CFG_PLL_STRIDE; w++) begin
						act_mem[p*`CFG_PLL_STRIDE + w] <= cfg_mem[p*`CFG_PLL_STRIDE + w];
					end
				end
			end
			if (soft_reg == 4'hf) begin
				act_mem[`CFG_XPOINT_IDX] <= cfg_mem[`CFG_XPOINT_IDX];
			end
		end
	end

	// per pll mode machines, all independent
	pll_ctrl_pkg::mode_t mode_reg [`PLL_COUNT];
	logic [1:0]          sel_reg [`PLL_COUNT];
	logic [3:0]          ever_locked_reg;
	logic [3:0]          lock_evt;
	logic [3:0]          hold_evt;

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			for (int p = 0; p < `PLL_COUNT; p++) begin
				mode_reg[p] <= pll_ctrl_pkg::MODE_FREE_RUN;
				sel_reg[p]  <= 2'h0;
			end
			ever_locked_reg <= 4'h0;
			lock_evt        <= 4'h0;
			hold_evt        <= 4'h0;
		end else begin
			lock_evt <= 4'h0;
			hold_evt <= 4'h0;
			for (int p = 0; p < `PLL_COUNT; p++) begin
				logic [3:0] cand;
				logic [2:0] pick;
				cand = valid_reg & cand_mask(act_mem[p*`CFG_PLL_STRIDE + `CFG_CTRL_OFS]);
				pick = pick_input(cand);
				if (!phase_is_run || soft_reg[p]) begin
					// soft reset restarts only this pll from free-run
					mode_reg[p]        <= pll_ctrl_pkg::MODE_FREE_RUN;
					ever_locked_reg[p] <= ever_locked_reg[p] & phase_is_run;
				end else begin
					unique case (mode_reg[p])
						pll_ctrl_pkg::MODE_FREE_RUN: begin
							if (pick[2]) begin
								mode_reg[p] <= pll_ctrl_pkg::MODE_LOCK_ACQ;
								sel_reg[p]  <= pick[1:0];
							end
						end
						pll_ctrl_pkg::MODE_LOCK_ACQ: begin
							if (!cand[sel_reg[p]]) begin
								if (pick[2]) begin
									sel_reg[p] <= pick[1:0];
								end else if (ever_locked_reg[p]) begin
									mode_reg[p] <= pll_ctrl_pkg::MODE_HOLDOVER;
									hold_evt[p] <= 1'b1;
								end else begin
									mode_reg[p] <= pll_ctrl_pkg::MODE_FREE_RUN;
								end
							end else if (lock_reg[p]) begin
								mode_reg[p]        <= pll_ctrl_pkg::MODE_LOCKED;
								ever_locked_reg[p] <= 1'b1;
								lock_evt[p]        <= 1'b1;
							end
						end
						pll_ctrl_pkg::MODE_LOCKED: begin
							if (!cand[sel_reg[p]]) begin
								if (pick[2]) begin
									mode_reg[p] <= pll_ctrl_pkg::MODE_LOCK_ACQ;
									sel_reg[p]  <= pick[1:0];
								end else begin
									mode_reg[p] <= pll_ctrl_pkg::MODE_HOLDOVER;
									hold_evt[p] <= 1'b1;
								end
							end
						end
						pll_ctrl_pkg::MODE_HOLDOVER: begin
							if (pick[2]) begin
								mode_reg[p] <= pll_ctrl_pkg::MODE_LOCK_ACQ;
								sel_reg[p]  <= pick[1:0];
							end
						end
					endcase
				end
			end
		end
	end

	// bandwidth and plan outputs; fastlock code clamped to its 100 Hz floor
	always_comb begin
		for (int p = 0; p < `PLL_COUNT; p++) begin
			logic [31:0] c;
			logic [4:0]  loop_bw;
			logic [4:0]  fast_bw;
			c       = act_mem[p*`CFG_PLL_STRIDE + `CFG_CTRL_OFS];
			loop_bw = c[`CTRL_LOOP_BW_LSB +: 5];
			fast_bw = c[`CTRL_FAST_BW_LSB +: 5];
			if (loop_bw > `BW_CODE_MAX) loop_bw = `BW_CODE_MAX;
			if (fast_bw > `BW_CODE_MAX) fast_bw = `BW_CODE_MAX;
			if (fast_bw < `FAST_BW_CODE_MIN) fast_bw = `FAST_BW_CODE_MIN;
			if (c[`CTRL_FAST_EN_BIT] && (mode_reg[p] == pll_ctrl_pkg::MODE_LOCK_ACQ)) begin
				PLL_BW_O[5*p +: 5] = fast_bw;
			end else begin
				PLL_BW_O[5*p +: 5] = loop_bw;
			end
			PLL_PDIV_O[32*p +: 32] = act_mem[p*`CFG_PLL_STRIDE + `CFG_PDIV_OFS];
			PLL_MDIV_O[32*p +: 32] = act_mem[p*`CFG_PLL_STRIDE + `CFG_MDIV_OFS];
			PLL_RDIV_O[32*p +: 32] = act_mem[p*`CFG_PLL_STRIDE + `CFG_RDIV_OFS];
			PLL_MODE_O[2*p +: 2]   = mode_reg[p];
			PLL_INSEL_O[2*p +: 2]  = sel_reg[p];
			// only lock acquisition and locked steer from an input; else reference only
			PLL_TRACK_INPUT_O[p]   = (mode_reg[p] == pll_ctrl_pkg::MODE_LOCK_ACQ)
				|| (mode_reg[p] == pll_ctrl_pkg::MODE_LOCKED);
		end
	end

	// output crosspoint, held off until the load is done
	assign OUT_PLL_SEL_O = act_mem[`CFG_XPOINT_IDX][`XPT_SEL_LSB +: 16];
	assign OUT_EN_O      = phase_is_run ? act_mem[`CFG_XPOINT_IDX][`XPT_EN_LSB +: 8] : 8'h00;

	// sticky interrupt status, write one to clear; a new event wins over the clear
	logic [`INT_WIDTH-1:0] int_stat_reg;
	logic [`INT_WIDTH-1:0] int_mask_reg;
	logic [`INT_WIDTH-1:0] int_evt;
	logic [`INT_WIDTH-1:0] int_clr;

	assign int_evt = {hold_evt, lock_evt, load_done && !phase_is_run};
	assign int_clr = (wr_ack && (adr == `REG_INT_STAT_ADDR)) ? WB_DAT_I[`INT_WIDTH-1:0] : 9'h000;

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			int_stat_reg <= 9'h000;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clr) | int_evt;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			int_mask_reg <= `INT_MASK_RESET;
		end else if (wr_ack && (adr == `REG_INT_MASK_ADDR)) begin
			int_mask_reg <= WB_DAT_I[`INT_WIDTH-1:0];
		end
	end

	assign IRQ_O = |(int_stat_reg & int_mask_reg);

	// read data, registered with the ack; unmapped words read zero
	always_ff @(posedge REF_CLK_I) begin
		if (rst_all) begin
			rdat_reg <= 32'h00000000;
		end else if (WB_CYC_I && WB_STB_I && !ack_reg && phase_is_run) begin
			rdat_reg <= 32'h00000000;
			if (is_cfg) begin
				rdat_reg <= cfg_mem[cfg_idx];
			end else if (WB_ADR_I[31:8] == 24'h000000) begin
				unique case (adr)
					`REG_STATUS_ADDR: begin
						rdat_reg[`STS_INIT_DONE_BIT] <= phase_is_run;
						rdat_reg[`STS_MODE_LSB +: 8] <= PLL_MODE_O;
						rdat_reg[`STS_SEL_LSB +: 8]  <= PLL_INSEL_O;
					end
					`REG_INT_STAT_ADDR: rdat_reg[`INT_WIDTH-1:0] <= int_stat_reg;
					`REG_INT_MASK_ADDR: rdat_reg[`INT_WIDTH-1:0] <= int_mask_reg;
					default:            rdat_reg <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : pll_mode_and_reset_control

// File: inc/pll_ctrl_regs.svh
// register offsets, field positions, reset values and counts of the pll mode controller
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH

// sizes of the device
`define PLL_COUNT          4
`define INPUT_COUNT        4
`define OUTPUT_COUNT       8

// configuration words loaded from nvm, byte address = index * 4
`define CFG_WORDS          17
`define CFG_LAST_IDX       5'h10
`define CFG_PLL_STRIDE     4
`define CFG_CTRL_OFS       0
`define CFG_PDIV_OFS       1
`define CFG_MDIV_OFS       2
`define CFG_RDIV_OFS       3
`define CFG_XPOINT_IDX     16

// other registers, byte addresses
`define REG_CFG_LAST_ADDR  8'h40
`define REG_CONTROL_ADDR   8'h80
`define REG_STATUS_ADDR    8'h84
`define REG_INT_STAT_ADDR  8'h88
`define REG_INT_MASK_ADDR  8'h8c

// per pll control word fields
`define CTRL_LOOP_BW_LSB   0
`define CTRL_FAST_BW_LSB   5
`define CTRL_FAST_EN_BIT   10
`define CTRL_AUTO_SEL_BIT  11
`define CTRL_MAN_IN_LSB    12
`define CTRL_IN_MASK_LSB   16

// bandwidth codes: 0 = 0.1 Hz up to 23 = 4 kHz; fastlock floor 100 Hz
`define BW_CODE_MAX        5'h17
`define FAST_BW_CODE_MIN   5'h0c

// crosspoint word fields
`define XPT_SEL_LSB        0
`define XPT_EN_LSB         16

// control register bits
`define CTL_HARD_BIT       0
`define CTL_SOFT_ALL_BIT   1
`define CTL_SOFT_PLL_LSB   2

// status register fields
`define STS_INIT_DONE_BIT  0
`define STS_MODE_LSB       4
`define STS_SEL_LSB        12

// interrupt bits
`define INT_INIT_BIT       0
`define INT_LOCK_LSB       1
`define INT_HOLD_LSB       5
`define INT_WIDTH          9
`define INT_MASK_RESET     9'h000

`endif

// File: inc/pll_ctrl_pkg.sv
// types shared by the pll mode and reset controller
package pll_ctrl_pkg;
	typedef enum logic [1:0] {MODE_FREE_RUN, MODE_LOCK_ACQ, MODE_LOCKED, MODE_HOLDOVER} mode_t;
	typedef enum logic {PH_NVM_LOAD, PH_RUN} phase_t;
endpackage : pll_ctrl_pkg

// File: verif/pll_ctrl_checker.sv
// concurrent checks on the ports of the pll mode and reset controller
`timescale 1ns/1ns

module pll_ctrl_checker (
	input  wire logic       REF_CLK_I,
	input  wire logic       RST_I,
	input  wire logic       HARD_RESET_PIN_N_I,
	input  wire logic       WB_CYC_I,
	input  wire logic       WB_STB_I,
	input  wire logic       WB_ACK_O,
	input  wire logic       NVM_RD_O,
	input  wire logic       INIT_DONE_O,
	input  wire logic [7:0] PLL_MODE_O,
	input  wire logic [3:0] PLL_TRACK_INPUT_O,
	input  wire logic [7:0] OUT_EN_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	// a request that the running controller may take, and a pin held low long enough to sync
	sequence req_s;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && INIT_DONE_O;
	endsequence
	sequence pin_low_s;
		!HARD_RESET_PIN_N_I [*4];
	endsequence

	bus_gated_a: assert property (WB_ACK_O |-> $past(INIT_DONE_O))
		else $error("ack given while loading");
	ack_answer_a: assert property (req_s |=> WB_ACK_O)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	clocks_off_a: assert property (!INIT_DONE_O |-> OUT_EN_O == 8'h00)
		else $error("output enabled before init done");
	load_first_a: assert property (NVM_RD_O |-> !INIT_DONE_O)
		else $error("nvm read while running");
	load_done_a: assert property ($fell(NVM_RD_O) |-> ##[0:2] INIT_DONE_O)
		else $error("init done late after nvm load");
	free_run_a: assert property ($rose(INIT_DONE_O) |-> PLL_MODE_O == 8'h00)
		else $error("pll not free-running after init");
	pin_reset_a: assert property (pin_low_s |-> !INIT_DONE_O && OUT_EN_O == 8'h00)
		else $error("reset pin ignored");
	track_mode_a: assert property (
		PLL_TRACK_INPUT_O[0] == (PLL_MODE_O[1:0] inside {2'h1, 2'h2}))
		else $error("tracking flag disagrees with mode");
endmodule : pll_ctrl_checker

// File: verif/nvm_model.sv
// behavioural nvm holding the power-up configuration words
`timescale 1ns/1ns

module nvm_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic [4:0]  addr_i,
	output logic      [31:0] data_o
);
	logic [31:0] word_reg = 32'h5a5a_c3c3;

	// ctrl words: loop code pll+1, fast code 0x14, auto select over all inputs, fastlock on pll0
	function automatic logic [31:0] word_of(input logic [4:0] idx);
		if (idx == 5'h10) begin
			return 32'h00ff_e4e4; // outputs spread round the plls, all enabled
		end
		if (idx[1:0] == 2'h0) begin
			return 32'h000f_0a81 + {29'h0, idx[4:2]} + ((idx[4:2] == 3'h0) ? 32'h400 : 32'h0);
		end
		return 32'h0001_0000 + {27'h0, idx};
	endfunction : word_of

	// one-cycle latency; outside a read the data toggles so stale words never pass as valid
	always @(posedge clk_i) begin
		if (rd_i) begin
			word_reg <= word_of(addr_i);
		end else begin
			word_reg <= ~word_reg;
		end
	end
	assign data_o = word_reg;
endmodule : nvm_model

// File: verif/tb_top.sv
// self-checking bench of the pll mode and reset controller
`timescale 1ns/1ns

module tb_top;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic         pin_n = 1'b1;
	logic         cyc = 1'b0;
	logic         stb = 1'b0;
	logic         we = 1'b0;
	logic [3:0]   sel = 4'h0;
	logic [31:0]  adr = 32'h0;
	logic [31:0]  wdat = 32'h0;
	logic [3:0]   valid = 4'h0;
	logic [3:0]   locked = 4'h0;
	logic [31:0]  rdat, nvm_data;
	logic         ack, nvm_rd, init_done, irq;
	logic [4:0]   nvm_addr;
	logic [7:0]   mode, insel, out_en;
	logic [3:0]   track;
	logic [19:0]  bw;
	logic [127:0] pdiv, mdiv, rdiv;
	logic [15:0]  out_sel;
	int           failures = 0;
	int           compares = 0;

	// 250 MHz
	always #2 ref_clk = ~ref_clk;

	pll_mode_and_reset_control dut_u (.REF_CLK_I(ref_clk), .RST_I(rst), .HARD_RESET_PIN_N_I(pin_n),
		.WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .NVM_RD_O(nvm_rd), .NVM_ADDR_O(nvm_addr),
		.NVM_DATA_I(nvm_data), .INPUT_VALID_I(valid), .PLL_LOCKED_I(locked),
		.INIT_DONE_O(init_done), .PLL_MODE_O(mode), .PLL_INSEL_O(insel),
		.PLL_TRACK_INPUT_O(track), .PLL_BW_O(bw), .PLL_PDIV_O(pdiv), .PLL_MDIV_O(mdiv),
		.PLL_RDIV_O(rdiv), .OUT_PLL_SEL_O(out_sel), .OUT_EN_O(out_en), .IRQ_O(irq));
	nvm_model nvm_u (.clk_i(ref_clk), .rd_i(nvm_rd), .addr_i(nvm_addr), .data_o(nvm_data));

	task chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// classic cycle: hold everything until ack is sampled, then release for at least a cycle
	task wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 200);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 200) failures++;
	endtask : wb

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(what, q, exp);
	endtask : rd_chk

	// bounded waits on settled outputs
	task wait_init(input logic v);
		int n;
		n = 0;
		while (init_done !== v && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("init done", init_done, v);
	endtask : wait_init

	task wait_mode(input logic [7:0] m);
		int n;
		n = 0;
		while (mode !== m && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("pll modes", mode, m);
	endtask : wait_mode

	task test_init;
		logic [31:0] q;
		wb(1'b0, 32'h84, 32'h0, q); // issued during the load and stalled
		chk("status", q[11:0], 12'h001);
		chk("clock enables", out_en, 8'hff);
		for (int p = 0; p < 4; p++) begin
			chk("pdiv", pdiv[32*p+:32], 32'h0001_0001 + 4 * p);
			chk("mdiv", mdiv[32*p+:32], 32'h0001_0002 + 4 * p);
			chk("rdiv", rdiv[32*p+:32], 32'h0001_0003 + 4 * p);
		end
		chk("bandwidths", bw, {5'h04, 5'h03, 5'h02, 5'h01});
		chk("output map", out_sel, 16'he4e4);
		$display("test init finished");
	endtask : test_init

	task test_lock;
		wr(32'h8c, 32'h2);
		chk("irq masked", irq, 1'b0);
		valid <= 4'h4;
		wait_mode(8'h55);
		chk("inputs chosen", insel, 8'haa);
		chk("fastlock bw", bw, {5'h04, 5'h03, 5'h02, 5'h14});
		chk("tracking", track, 4'hf);
		@(posedge ref_clk);
		locked <= 4'hf;
		wait_mode(8'haa);
		chk("loop bw", bw, {5'h04, 5'h03, 5'h02, 5'h01});
		// lock events are registered, so the status bit lands one edge after the mode
		@(posedge ref_clk);
		#1;
		chk("irq on lock", irq, 1'b1);
		rd_chk("int status", 32'h88, 32'h1f);
		wr(32'h88, 32'h2);
		rd_chk("int cleared", 32'h88, 32'h1d);
		chk("irq cleared", irq, 1'b0);
		$display("test lock finished");
	endtask : test_lock

	task test_hold;
		@(posedge ref_clk);
		valid <= 4'h0;
		wait_mode(8'hff);
		chk("tracking", track, 4'h0);
		chk("irq hold masked", irq, 1'b0);
		$display("test hold finished");
	endtask : test_hold

	task test_soft;
		wr(32'h10, 32'h000f_0a87);
		chk("bw before soft", bw[9:5], 5'h02);
		wr(32'h80, 32'h8);
		wait_mode(8'hf3);
		chk("bw after soft", bw[9:5], 5'h07);
		chk("still running", init_done, 1'b1);
		rd_chk("cfg kept", 32'h10, 32'h000f_0a87);
		rd_chk("unmapped", 32'h90, 32'h0);
		wr(32'h80, 32'h2);
		wait_mode(8'h00);
		// pll2 goes manual on input 3; only input 0 valid, so it must stay in free-run
		wr(32'h20, 32'h0000_3001);
		wr(32'h80, 32'h10);
		valid <= 4'h1;
		wait_mode(8'h8a);
		@(posedge ref_clk);
		valid <= 4'h9;
		wait_mode(8'haa);
		chk("manual input", insel, 8'h30);
		@(posedge ref_clk);
		valid <= 4'h0;
		$display("test soft finished");
	endtask : test_soft

	task test_hard;
		wr(32'h80, 32'h1);
		wait_init(1'b0);
		wait_init(1'b1);
		chk("bw reloaded", bw[9:5], 5'h02);
		rd_chk("mask reset", 32'h8c, 32'h0);
		rd_chk("cfg reloaded", 32'h10, 32'h000f_0a82);
		@(posedge ref_clk);
		pin_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		chk("pin reset", init_done, 1'b0);
		chk("clocks off", out_en, 8'h00);
		@(posedge ref_clk);
		pin_n <= 1'b1;
		wait_init(1'b1);
		chk("free run", mode, 8'h00);
		$display("test hard finished");
	endtask : test_hard

	task results;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		test_init;
		test_lock;
		test_hold;
		test_soft;
		test_hard;
		results;
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		results;
	end
endmodule : tb_top

bind pll_mode_and_reset_control pll_ctrl_checker chk_u (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
	.HARD_RESET_PIN_N_I(HARD_RESET_PIN_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .NVM_RD_O(NVM_RD_O), .INIT_DONE_O(INIT_DONE_O), .PLL_MODE_O(PLL_MODE_O),
	.PLL_TRACK_INPUT_O(PLL_TRACK_INPUT_O), .OUT_EN_O(OUT_EN_O));
